// File: verilog/imuf_pkg.sv
/*
 * Shared constants and types for the sample framer: link timing,
 * sample timing, message bytes and the sample carrier structs.
 * Assumes a single 40 MHz clock for all users of the package.
 */
package imuf_pkg;
  // Clock, link and sample timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned BAUD_BPS       = 460_800;
  // Bit time rounds down: 86 cycles, 0.9 % fast, inside UART margin
  localparam int unsigned BIT_CYC        = CLK_HZ / BAUD_BPS;
  localparam int unsigned SAMPLE_RATE_HZ = 800;
  localparam int unsigned SAMPLE_CYC     = CLK_HZ / SAMPLE_RATE_HZ;
  localparam logic [9:0]  SUBSEC_LAST    = 10'(SAMPLE_RATE_HZ - 1);
  localparam logic [9:0]  SUBSEC_HALF    = 10'(SAMPLE_RATE_HZ / 2);
  localparam logic [15:0] DECIM_DEFAULT  = 16'h0001;

  // Message layout
  localparam logic [7:0] FRAME_MARKER  = 8'ha5;
  localparam logic [7:0] MSG_TYPE_SMP  = 8'ha2;
  localparam logic [7:0] PAYLOAD_LEN   = 8'h1c;
  localparam logic [7:0] CODE_ACCEL    = 8'h81;
  localparam logic [7:0] CODE_RATE     = 8'h82;
  localparam logic [7:0] FIELD_LEN     = 8'h0c;
  localparam logic [5:0] IDX_TYPE      = 6'h02;
  localparam logic [5:0] IDX_LEN       = 6'h03;
  localparam logic [5:0] IDX_ACC_CODE  = 6'h04;
  localparam logic [5:0] IDX_ACC_LEN   = 6'h05;
  localparam logic [5:0] IDX_ACC_DATA  = 6'h06;
  localparam logic [5:0] IDX_RATE_CODE = 6'h12;
  localparam logic [5:0] IDX_RATE_LEN  = 6'h13;
  localparam logic [5:0] IDX_RATE_DATA = 6'h14;
  localparam logic [5:0] IDX_CK1       = 6'h20;
  localparam logic [5:0] IDX_CK2       = 6'h21;

  // One vector field: X, Y, Z as 32-bit floats
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
  } imuf_vec_t;

  // One compensated sample
  typedef struct packed {
    imuf_vec_t accel;
    imuf_vec_t rate;
  } imuf_sample_t;

  typedef enum logic [1:0] {
    IMUF_IDLE,
    IMUF_SEND,
    IMUF_WAIT
  } imuf_state_t;
endpackage

// File: verilog/imuf_uart_tx.sv
/*
 * Serial byte transmitter, 8N1, LSB first, differential pair out.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/100ps
module imuf_uart_tx
  import imuf_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = imuf_pkg::BIT_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            line_p,
  output logic            line_n
);
  logic [9:0]  shift_r;    // Stop, data, start
  logic [3:0]  bit_cnt_r;  // Bit being sent
  logic [15:0] div_r;      // Cycles within bit
  logic        busy_r;
  logic        line_r;
  logic        bit_end;    // One-cycle bit enable

  if (BIT_CYCLES < 2 || BIT_CYCLES > 65535)
    $error("imuf_uart_tx: BIT_CYCLES out of range");

  assign bit_end = busy_r && (div_r == 16'(BIT_CYCLES - 1));
  assign busy    = busy_r;
  assign line_p  = line_r;
  assign line_n  = ~line_r;

  // Shifter; line idles at mark level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r   <= 10'h3ff;
      bit_cnt_r <= 4'h0;
      div_r     <= 16'h0000;
      busy_r    <= 1'b0;
      line_r    <= 1'b1;
    end
    else if (start && !busy_r)
    begin
      shift_r   <= {1'b1, data, 1'b0};  // One start, 8 data, one stop
      bit_cnt_r <= 4'h0;
      div_r     <= 16'h0000;
      busy_r    <= 1'b1;
      line_r    <= 1'b0;
    end
    else if (bit_end)
    begin
      div_r <= 16'h0000;
      if (bit_cnt_r == 4'h9)
        busy_r <= 1'b0;                  // Stop bit done
      else
      begin
        shift_r   <= {1'b1, shift_r[9:1]};
        line_r    <= shift_r[1];         // LSB first
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
    else if (busy_r)
      div_r <= div_r + 16'h0001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_stop_mark: assert property (
    $fell(busy_r) |-> line_r && $past(line_r, 2))
    else $error("stop bit not at mark level");
  chk_idle_mark: assert property (
    !busy_r |-> line_r)
    else $error("line not at mark while idle");
endmodule

// File: verilog/imuf_framer.sv
/*
 * Sample timing, validity strobe, trigger and time keeping, and
 * framing of compensated samples into data messages on the link.
 * Assumes a compensation stage that answers each sample_start with
 * one sample_done pulse carrying the finished sample, and that
 * trigger mode and decimation are set by the command handler.
 */
`timescale 1ns/100ps
module imuf_framer
#(
  parameter int unsigned SAMPLE_PERIOD_CYC = imuf_pkg::SAMPLE_CYC,
  parameter int unsigned BIT_CYCLES        = imuf_pkg::BIT_CYC
)
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   trigger_mode_en,
  input  wire logic [15:0]            decimation,
  input  wire logic                   external_sample_trigger,
  input  wire logic                   pulse_per_second_in,
  input  wire imuf_pkg::imuf_sample_t sample_in,
  input  wire logic                   sample_done,
  output logic                        sample_start,
  output logic                        sample_validity_strobe,
  output logic                        serial_tx_positive,
  output logic                        serial_tx_negative,
  output logic [31:0]                 time_seconds,
  output logic [9:0]                  time_subsec
);
  import imuf_pkg::*;

  if (SAMPLE_PERIOD_CYC < 2)
    $error("imuf_framer: SAMPLE_PERIOD_CYC too small");

  // Byte index to its message byte, checksum passed in
  function automatic logic [7:0] frame_byte(
    input logic [5:0]   idx,
    input imuf_sample_t smp,
    input logic [7:0]   ck1,
    input logic [7:0]   ck2
  );
    logic [5:0] off;
    logic [7:0] b;
    off = 6'h00;
    b   = FRAME_MARKER;                      // Bytes 0 and 1
    if (idx == IDX_TYPE)
      b = MSG_TYPE_SMP;
    else if (idx == IDX_LEN)
      b = PAYLOAD_LEN;
    else if (idx == IDX_ACC_CODE)
      b = CODE_ACCEL;
    else if (idx == IDX_ACC_LEN || idx == IDX_RATE_LEN)
      b = FIELD_LEN;
    else if (idx == IDX_RATE_CODE)
      b = CODE_RATE;
    else if (idx >= IDX_ACC_DATA && idx < IDX_RATE_CODE)
    begin
      off = idx - IDX_ACC_DATA;
      b   = smp.accel[95 - 8 * off -: 8];    // X,Y,Z MSB first
    end
    else if (idx >= IDX_RATE_DATA && idx < IDX_CK1)
    begin
      off = idx - IDX_RATE_DATA;
      b   = smp.rate[95 - 8 * off -: 8];
    end
    else if (idx == IDX_CK1)
      b = ck1;                               // Block one first
    else if (idx == IDX_CK2)
      b = ck2;
    return b;
  endfunction

  // Fletcher-16 running sums wrap at 256; the carry is dropped on
  // purpose, a modulo-255 sum would not match the host's checker
  function automatic logic [7:0] sum_add(
    input logic [7:0] a,
    input logic [7:0] b
  );
    return a + b;
  endfunction

  logic [31:0]  div_cnt_r;     // Sample period divider
  logic [15:0]  dec_cnt_r;     // Samples left before next output
  imuf_state_t  state_r;       // Frame sequencer
  logic [5:0]   idx_r;         // Byte being sent
  logic [7:0]   sum1_r;        // Fletcher block one
  logic [7:0]   sum2_r;        // Fletcher block two
  imuf_sample_t frame_r;       // Sample in flight
  imuf_sample_t latest_r;      // Newest completed sample
  logic         pend_r;        // Sample awaited for output
  logic         strobe_r;      // Validity strobe level
  logic         start_r;       // Sample start pulse
  logic         tx_go_r;       // Byte start to transmitter
  logic [7:0]   tx_byte_r;     // Byte handed over
  logic         trig_d_r;      // Trigger, last cycle
  logic         pps_d_r;       // Second pulse, last cycle
  logic [31:0]  sec_r;         // Whole seconds
  logic [9:0]   sub_r;         // Samples within second
  logic         tx_busy;       // Transmitter busy

  logic         tick;          // One-cycle 800 Hz enable
  logic         sel;           // This sample goes out
  logic         trig_rise;     // Accepted trigger edge
  logic         pps_rise;      // Second pulse edge
  logic         idle;          // No frame in flight
  logic         go_internal;   // Internal mode frame start
  logic         go_trigger;    // Trigger mode frame start
  logic         frame_end;     // Last bit left the line
  logic [7:0]   cur_byte;      // Byte at idx_r
  logic [7:0]   sum1_nxt;
  logic [7:0]   sum2_nxt;
  logic [15:0]  dec_reload;    // Decimation, zero read as one

  // Decode and selection
  assign tick      = (div_cnt_r == 32'(SAMPLE_PERIOD_CYC - 1));
  assign sel       = (dec_cnt_r == 16'h0000);
  assign idle      = (state_r == IMUF_IDLE);
  assign trig_rise = trigger_mode_en && external_sample_trigger
                     && !trig_d_r;
  assign pps_rise  = pulse_per_second_in && !pps_d_r;
  assign go_internal = !trigger_mode_en && pend_r && sample_done && idle;
  assign go_trigger  = trig_rise && idle;
  assign frame_end = (state_r == IMUF_WAIT) && (idx_r == IDX_CK2)
                     && !tx_busy && !tx_go_r;
  assign cur_byte  = frame_byte(idx_r, frame_r, sum1_r, sum2_r);
  assign sum1_nxt  = sum_add(sum1_r, cur_byte);
  assign sum2_nxt  = sum_add(sum2_r, sum1_nxt);
  assign dec_reload = (decimation == 16'h0000) ? 16'h0000
                      : decimation - 16'h0001;

  // Fixed-rate sample divider
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_cnt_r <= 32'h0000_0000;
    else if (tick)
      div_cnt_r <= 32'h0000_0000;
    else
      div_cnt_r <= div_cnt_r + 32'h0000_0001;
  end

  // Decimation: one output per decimation samples
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dec_cnt_r <= 16'h0000;
    else if (tick)
      dec_cnt_r <= sel ? dec_reload : dec_cnt_r - 16'h0001;
  end

  // Sensor sampling request, one pulse per period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      start_r <= 1'b0;
    else
      start_r <= tick;
  end

  // Edge detectors on the synchronous pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_d_r <= 1'b0;
      pps_d_r  <= 1'b0;
    end
    else
    begin
      trig_d_r <= external_sample_trigger;
      pps_d_r  <= pulse_per_second_in;
    end
  end

  // Newest finished sample; signs come right-handed from compensation
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      latest_r <= '0;
    else if (sample_done)
      latest_r <= sample_in;
  end

  // Internal mode: remember a selected sample is on its way.
  // A selected sample is skipped if the link is still busy.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_r <= 1'b0;
    else if (trigger_mode_en || go_internal)
      pend_r <= 1'b0;
    else if (tick && sel && idle)
      pend_r <= 1'b1;
  end

  // Validity strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      strobe_r <= 1'b1;
    else if (trigger_mode_en)
    begin
      if (tick)
        strobe_r <= 1'b0;                      // Sample begins
      else if (sample_done)
        strobe_r <= 1'b1;                      // Compensation done
    end
    else if (tick && sel && idle)
      strobe_r <= 1'b0;                        // First element taken
    else if (frame_end)
      strobe_r <= 1'b1;                        // Last bit gone
  end

  // Frame sequencer: hand bytes to the transmitter one by one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= IMUF_IDLE;
      idx_r     <= 6'h00;
      sum1_r    <= 8'h00;
      sum2_r    <= 8'h00;
      frame_r   <= '0;
      tx_go_r   <= 1'b0;
      tx_byte_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        IMUF_IDLE:
        begin
          tx_go_r <= 1'b0;
          idx_r   <= 6'h00;
          sum1_r  <= 8'h00;
          sum2_r  <= 8'h00;
          if (go_internal)
          begin
            frame_r <= sample_in;
            state_r <= IMUF_SEND;
          end
          else if (go_trigger)
          begin
            // Sample finishing this cycle is the newest
            frame_r <= sample_done ? sample_in : latest_r;
            state_r <= IMUF_SEND;
          end
        end
        IMUF_SEND:
        begin
          tx_go_r   <= 1'b1;
          tx_byte_r <= cur_byte;
          if (idx_r < IDX_CK1)
          begin
            sum1_r <= sum1_nxt;
            sum2_r <= sum2_nxt;
          end
          state_r <= IMUF_WAIT;
        end
        IMUF_WAIT:
        begin
          tx_go_r <= 1'b0;
          if (!tx_busy && !tx_go_r)
          begin
            if (idx_r == IDX_CK2)
              state_r <= IMUF_IDLE;
            else
            begin
              idx_r   <= idx_r + 6'h01;
              state_r <= IMUF_SEND;
            end
          end
        end
      endcase
    end
  end

  // Time keeping; second pulse rounds to the nearest second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sec_r <= 32'h0000_0000;
      sub_r <= 10'h000;
    end
    else if (pps_rise)
    begin
      sub_r <= 10'h000;
      if (sub_r >= SUBSEC_HALF)
        sec_r <= sec_r + 32'h0000_0001;       // Round up
    end
    else if (tick)
    begin
      if (sub_r == SUBSEC_LAST)
      begin
        sub_r <= 10'h000;
        sec_r <= sec_r + 32'h0000_0001;
      end
      else
        sub_r <= sub_r + 10'h001;
    end
  end

  // Serial transmitter
  imuf_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk    (clk),
    .rst    (rst),
    .start  (tx_go_r),
    .data   (tx_byte_r),
    .busy   (tx_busy),
    .line_p (serial_tx_positive),
    .line_n (serial_tx_negative)
  );

  assign sample_start           = start_r;
  assign sample_validity_strobe = strobe_r;
  assign time_seconds           = sec_r;
  assign time_subsec            = sub_r;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_strobe_fall_int: assert property (
    !trigger_mode_en && tick && sel && idle |=> !strobe_r && start_r)
    else $error("strobe did not fall at sampling");
  chk_strobe_rise_int: assert property (
    !trigger_mode_en && !$past(trigger_mode_en) && $rose(strobe_r)
    |-> $past(frame_end) && !tx_busy)
    else $error("strobe rose before frame end");
  chk_strobe_rise_trg: assert property (
    trigger_mode_en && sample_done && !tick |=> strobe_r)
    else $error("strobe not high after compensation");
  chk_trig_ignored: assert property (
    idle && !trigger_mode_en && !pend_r |=> idle)
    else $error("frame started without trigger mode");
  chk_trig_starts: assert property (
    trigger_mode_en && idle && external_sample_trigger && !trig_d_r
    |=> state_r == IMUF_SEND ##1 tx_go_r)
    else $error("trigger edge did not start a frame");
  chk_marker_bytes: assert property (
    state_r == IMUF_SEND && idx_r < IDX_TYPE |=> tx_byte_r == 8'ha5)
    else $error("marker byte wrong");
  chk_header_bytes: assert property (
    state_r == IMUF_SEND && idx_r == IDX_LEN
    |=> tx_byte_r == 8'h1c && $past(tx_byte_r, 3) == 8'ha2)
    else $error("type or length byte wrong");
  chk_field_codes: assert property (
    state_r == IMUF_SEND && idx_r == IDX_RATE_CODE
    |=> tx_byte_r == 8'h82)
    else $error("rate field code wrong");
  chk_pps_round: assert property (
    pps_rise && sub_r >= SUBSEC_HALF |=> sub_r == 10'h000
    && sec_r == $past(sec_r) + 32'h0000_0001)
    else $error("second pulse did not round up");
  chk_sample_rate: assert property (
    tick |=> !tick [*8])
    else $error("sample ticks too close");
endmodule

// File: sim/imuf_host_model.sv
/*
 * Far-side model: a compensation stage that answers every sample_start
 * and a host receiver that decodes the serial link.
 * Assumes the framer's bit time is BITC cycles of the shared clock.
 */
`timescale 1ns/100ps
module imuf_host_model
#(
  parameter int unsigned BITC = 4,
  parameter int unsigned LAT  = 6
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             sample_start,
  input  wire logic             line_p,
  input  wire logic             line_n,
  output logic                  sample_done,
  output imuf_pkg::imuf_sample_t sample_in,
  output imuf_pkg::imuf_sample_t smp_last,
  output logic                  rx_valid,
  output logic [7:0]            rx_byte,
  output logic                  rx_ok
);
  import imuf_pkg::*;

  logic [31:0] n_smp; // Samples answered so far

  // Data is valid only with done; show the inverse at other times
  assign sample_in = sample_done ? smp_last : ~smp_last;

  // Compensation: one done pulse LAT cycles after each start
  initial
  begin
    sample_done = 1'b0;
    n_smp = 32'h0;
    smp_last = '0;
    forever
    begin
      @(posedge clk);
      if (!rst && sample_start === 1'b1)
      begin
        repeat (LAT - 1) @(posedge clk);
        // Counter folded in so every sample differs from the last
        smp_last <= {32'h37a7c5ac + n_smp, 32'h377ba882, 32'h3f800065,
                     32'h37a7c5ac, 32'h377ba882 + n_smp, 32'h3749539c};
        n_smp <= n_smp + 32'h1;
        sample_done <= 1'b1;
        @(posedge clk);
        sample_done <= 1'b0;
      end
    end
  end

  // Host receiver: mid-bit sampling, the pair must stay complementary
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_ok = 1'b1;
    forever
    begin
      @(posedge clk);
      if (!rst && line_p === 1'b0)
      begin
        repeat (BITC / 2) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
          // Start bit still low at its middle, pair inverted
          if (line_n !== ~line_p || (i == 0 && line_p !== 1'b0))
            rx_ok <= 1'b0;
          repeat (BITC) @(posedge clk);
          if (i < 8)
            rx_byte[i] <= line_p;
        end
        // Stop bit must be mark, else a framing fault
        if (line_p !== 1'b1)
          rx_ok <= 1'b0;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
      end
    end
  end
endmodule

// File: sim/tb_top.sv
/*
 * Self-checking bench for the sample framer and the far-side model.
 * Assumes shortened bit and sample periods, set through parameters.
 */
`timescale 1ns/100ps
module tb_top;
  import imuf_pkg::*;

  localparam int unsigned BITC = 4;  // Short bit keeps frames brief
  localparam int unsigned PER  = 60; // Short sample period
  localparam int unsigned LAT  = 6;  // Compensation delay of model
  localparam logic [7:0] HDR [6] = '{8'ha5, 8'ha5, 8'ha2, 8'h1c,
                                     8'h81, 8'h0c};

  logic         clk;
  logic         rst;
  logic         trigger_mode_en;
  logic [15:0]  decimation;
  logic         external_sample_trigger;
  logic         pulse_per_second_in;
  imuf_sample_t sample_in;
  imuf_sample_t smp_last;
  logic         sample_done;
  logic         sample_start;
  logic         sample_validity_strobe;
  logic         serial_tx_positive;
  logic         serial_tx_negative;
  logic [31:0]  time_seconds;
  logic [9:0]   time_subsec;
  logic         rx_valid;
  logic [7:0]   rx_byte;
  logic         rx_ok;
  int           miscompares;
  int           n_checks;
  logic [15:0]  last_ck;     // Last two bytes of the latest frame

  imuf_framer #(
    .SAMPLE_PERIOD_CYC (PER),
    .BIT_CYCLES        (BITC)
  ) u_imuf_framer (
    .clk                     (clk),
    .rst                     (rst),
    .trigger_mode_en         (trigger_mode_en),
    .decimation              (decimation),
    .external_sample_trigger (external_sample_trigger),
    .pulse_per_second_in     (pulse_per_second_in),
    .sample_in               (sample_in),
    .sample_done             (sample_done),
    .sample_start            (sample_start),
    .sample_validity_strobe  (sample_validity_strobe),
    .serial_tx_positive      (serial_tx_positive),
    .serial_tx_negative      (serial_tx_negative),
    .time_seconds            (time_seconds),
    .time_subsec             (time_subsec)
  );

  imuf_host_model #(
    .BITC (BITC),
    .LAT  (LAT)
  ) u_imuf_host_model (
    .clk          (clk),
    .rst          (rst),
    .sample_start (sample_start),
    .line_p       (serial_tx_positive),
    .line_n       (serial_tx_negative),
    .sample_done  (sample_done),
    .sample_in    (sample_in),
    .smp_last     (smp_last),
    .rx_valid     (rx_valid),
    .rx_byte      (rx_byte),
    .rx_ok        (rx_ok)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Single end of run, also used by the watchdog
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait on one output: 0 strobe, 1 start, 2 byte, 3 done
  task automatic wait_sig(input int sel, input logic val, input int lim);
    logic cur;
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clk);
      case (sel)
        0: cur = sample_validity_strobe;
        1: cur = sample_start;
        2: cur = rx_valid;
        default: cur = sample_done;
      endcase
      if (cur === val)
        return;
    end
    check(32'h0, 32'h1); // Waited too long
  endtask

  // Reset held for three cycles, released at a falling edge
  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask

  // 1 us pulse on the trigger pin or on the second pulse pin
  task automatic pulse(input logic trg);
    if (trg)
      external_sample_trigger = 1'b1;
    else
      pulse_per_second_in = 1'b1;
    repeat (40) @(negedge clk);
    external_sample_trigger = 1'b0;
    pulse_per_second_in = 1'b0;
  endtask

  // Build the expected frame from s, then compare 34 received bytes
  task automatic get_frame(input imuf_sample_t s);
    logic [7:0]   e [34];
    logic [191:0] d;
    int           s1;
    int           s2;
    d = s;
    for (int i = 0; i < 6; i++)
      e[i] = HDR[i];
    e[18] = 8'h82;
    e[19] = 8'h0c;
    // Accel then rate, X Y Z, most significant byte first
    for (int i = 0; i < 24; i++)
      e[i < 12 ? i + 6 : i + 8] = d[191 - 8 * i -: 8];
    s1 = 0;
    s2 = 0;
    for (int i = 0; i < 32; i++)
    begin
      s1 = (s1 + e[i]) % 256;
      s2 = (s2 + s1) % 256;
    end
    e[32] = 8'(s1);
    e[33] = 8'(s2);
    for (int i = 0; i < 34; i++)
    begin
      wait_sig(2, 1'b1, 40 * BITC);
      last_ck = {last_ck[7:0], rx_byte};
      if (i < 4)
        check(32'(rx_byte), 32'(e[i]));
      else if (i < 32)
        check(32'(rx_byte), 32'(e[i]));
      else
        check(32'(rx_byte), 32'(e[i]));
    end
    check(32'(rx_ok), 32'h1);
  endtask

  // Internal rate: strobe falls with sampling, rises after last bit
  task automatic t_internal();
    do_reset();
    check(32'({serial_tx_positive, serial_tx_negative}), 32'h2);
    wait_sig(0, 1'b0, PER + 4);
    check(32'(sample_start), 32'h1);
    wait_sig(3, 1'b1, LAT + 2);
    get_frame(smp_last);
    // First sample holds the reference vectors; fixed checksum known
    check(32'(last_ck), 32'h0c23);
    check(32'(sample_validity_strobe), 32'h0);
    wait_sig(0, 1'b1, BITC + 4);
    check(32'(sample_validity_strobe), 32'h1);
  endtask

  // Decimated cadence, trigger ignored when off, then triggered frame
  task automatic t_trigger();
    logic prev;
    logic bad;
    int   n;
    decimation = 16'h001e;
    do_reset();
    wait_sig(0, 1'b0, 31 * PER + 4);
    n = 0;
    // Count ticks up to the next selected sample
    do
    begin
      prev = sample_validity_strobe;
      @(negedge clk);
      n += int'(sample_start === 1'b1);
    end while (!(prev === 1'b1 && sample_validity_strobe === 1'b0) && n < 40);
    check(32'(n), 32'h1e);
    wait_sig(0, 1'b1, 2000);
    bad = 1'b0;
    fork
      pulse(1'b1);
      repeat (200)
      begin
        @(negedge clk);
        bad |= (serial_tx_positive !== 1'b1);
      end
    join
    check(32'(bad), 32'h0);
    trigger_mode_en = 1'b1;
    wait_sig(3, 1'b1, PER + 4);
    repeat (5) @(negedge clk);
    // Strobe must rise on compensation while the frame still runs
    fork
      pulse(1'b1);
      get_frame(smp_last);
      begin
        wait_sig(1, 1'b1, PER + 4);
        check(32'(sample_validity_strobe), 32'h0);
        wait_sig(3, 1'b1, LAT + 2);
        wait_sig(0, 1'b1, 2);
        check(32'(sample_validity_strobe), 32'h1);
      end
    join
  endtask

  // Tick period and count, rounding below and at half a second
  task automatic t_time();
    int c;
    trigger_mode_en = 1'b0;
    decimation = 16'h0001;
    do_reset();
    wait_sig(1, 1'b1, PER + 4);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end while (sample_start !== 1'b1 && c < 2 * PER);
    check(32'(c), 32'(PER));
    repeat (3) @(negedge clk);
    check(32'(time_subsec), 32'h2);
    pulse(1'b0);
    check(32'(time_subsec), 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      repeat (399 + k) wait_sig(1, 1'b1, PER + 4);
      repeat (3) @(negedge clk);
      check(32'(time_subsec), 32'(399 + k));
      pulse(1'b0);
      check(time_seconds, 32'(k));
      check(32'(time_subsec), 32'h0);
    end
  endtask

  // Main sequence; every input has a value at time zero
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    trigger_mode_en = 1'b0;
    decimation = 16'h0001;
    external_sample_trigger = 1'b0;
    pulse_per_second_in = 1'b0;
    miscompares = 0;
    n_checks = 0;
    t_internal();
    t_trigger();
    t_time();
    print_verdict();
  end

  // Watchdog: the scenarios need about 60k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule
